// ==== hdl/rps_defines.svh ====
// register offsets, field positions and select codes for the pin select unit
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH

`define RPS_OFF_SER3_CLK_DATA 12'h000
`define RPS_OFF_SER3_SS 12'h004
`define RPS_OFF_MOD_SYNC 12'h008
`define RPS_OFF_DTC1 12'h00C
`define RPS_OFF_DTC23 12'h010
`define RPS_OFF_DTC45 12'h014
`define RPS_OFF_DTC6 12'h018
`define RPS_OFF_OUT0 12'h01C

`define RPS_HI_LSB 8
`define RPS_LO_LSB 0
`define RPS_SEL_W 7
`define RPS_FN_W 6

`define RPS_CODE_GROUND 7'h00
`define RPS_CODE_COMPARATOR_ONE_OUTPUT 7'h01
`define RPS_CODE_REMAPPABLE_PIN_124 7'h7F
`define RPS_CODE_INPUT_ONLY_PIN_124 7'h7C
`define RPS_PIN_124 124
`define RPS_FIELD_RESET 7'h00
`define RPS_FN_RESET 6'h00

`endif

// ==== hdl/rps_pkg.sv ====
// types shared by the pin select unit
`default_nettype none
package rps_pkg;
  typedef enum logic [2:0] {
    RPS_IDLE = 3'b001,
    RPS_ACCESS = 3'b010,
    RPS_DONE = 3'b100
  } rps_bus_state_t;

  typedef struct packed {
    rps_bus_state_t bus_state;
    logic [6:0] ser3_clk_sel;
    logic [6:0] ser3_data_sel;
    logic [6:0] ser3_ss_sel;
    logic [6:0] sync_sel;
    logic [6:0] dtc1_sel;
    logic [6:0] dtc2_sel;
    logic [6:0] dtc3_sel;
    logic [6:0] dtc4_sel;
    logic [6:0] dtc5_sel;
    logic [6:0] dtc6_sel;
    logic [5:0] pin35_fn;
    logic [5:0] pin20_fn;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] periph_in;
    logic pin35_out;
    logic pin20_out;
  } rps_state_t;
endpackage : rps_pkg
`default_nettype wire

// ==== hdl/rps_input_mux.sv ====
// one peripheral input multiplexer: ground, comparator or a remappable pin
`timescale 1ns/10ps
`default_nettype none
`include "rps_defines.svh"
module rps_input_mux #(
  parameter int NPINS = 128,
  parameter logic [6:0] TOP_CODE = `RPS_CODE_REMAPPABLE_PIN_124
) (
  input wire logic [6:0] sel,
  input wire logic comparator_one_output,
  input wire logic [NPINS-1:0] pins,
  output logic y
);
  always_comb begin
    if (sel == `RPS_CODE_GROUND) begin
      y = 1'b0; // [RULE1]
    end else if (sel == `RPS_CODE_COMPARATOR_ONE_OUTPUT) begin
      y = comparator_one_output; // [RULE2]
    end else if (sel == TOP_CODE) begin
      y = pins[`RPS_PIN_124]; // [RULE3] [RULE4]
    end else if (32'(sel) < NPINS) begin
      y = pins[sel]; // [RULE13]
    end else begin
      y = 1'b0;
    end
  end
endmodule : rps_input_mux
`default_nettype wire

// ==== hdl/rps_pin_select.sv ====
// pin select unit: apb select registers, input routing and output routing
//
// Overview of operation
// [RULE1] code zero ties peripheral input to ground
// [RULE2] code one feeds comparator one output
// [RULE3] serial3 selectors: all-ones code selects pin 124
// [RULE4] sync/deadtime selectors: code 1111100 selects input pin 124
// [RULE5] unimplemented bits ignore writes, read zero
// [RULE6] all fields read/write, reset to zero
// [RULE7] reg0: serial3 clock 14:8, data 6:0
// [RULE8] reg1: serial3 slave select in 6:0
// [RULE9] reg2: modulator sync selector in 14:8
// [RULE10] deadtime 1 at 14:8, 6 at 6:0
// [RULE11] deadtime 3,5 at 14:8; 2,4 at 6:0
// [RULE12] output reg: pin35 fn 13:8, pin20 fn 5:0
// [RULE13] middle codes pick pin by table
// [RULE14] each input muxes independently on own field
`timescale 1ns/10ps
`default_nettype none
`include "rps_defines.svh"
module rps_pin_select
  import rps_pkg::*;
#(
  parameter int NPINS = 128,
  parameter int NFUNCS = 64
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_one_output,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NFUNCS-1:0] periph_func_out,
  output logic serial3_clock_input,
  output logic serial3_data_input,
  output logic serial3_slave_select_input,
  output logic modulator_sync_input,
  output logic [5:0] deadtime_comp_input,
  output logic pin35_drive,
  output logic pin20_drive,
  output logic [5:0] pin35_function_field,
  output logic [5:0] pin20_function_field
);
  rps_state_t st;
  rps_state_t next_st;
  logic [9:0] mux_y;

  function automatic logic [6:0] hi_field(input logic [31:0] w);
    hi_field = w[`RPS_HI_LSB +: `RPS_SEL_W];
  endfunction : hi_field

  function automatic logic [6:0] lo_field(input logic [31:0] w);
    lo_field = w[`RPS_LO_LSB +: `RPS_SEL_W];
  endfunction : lo_field

  function automatic logic [31:0] pack2(input logic [6:0] hi,
                                        input logic [6:0] lo);
    pack2 = 32'h0000_0000; // [RULE5]
    pack2[`RPS_HI_LSB +: `RPS_SEL_W] = hi;
    pack2[`RPS_LO_LSB +: `RPS_SEL_W] = lo;
  endfunction : pack2

  function automatic logic fn_pick(input logic [5:0] fn,
                                   input logic [NFUNCS-1:0] f);
    // function zero means the pin carries no peripheral output
    if (fn == `RPS_FN_RESET || 32'(fn) >= NFUNCS) begin
      fn_pick = 1'b0;
    end else begin
      fn_pick = f[fn];
    end
  endfunction : fn_pick

  // serial3 selectors use the all-ones code for pin 124
  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_REMAPPABLE_PIN_124)
  ) u_mux_ser3_clk (
    .sel(st.ser3_clk_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[0])
  ); // [RULE3] [RULE14]

  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_REMAPPABLE_PIN_124)
  ) u_mux_ser3_data (
    .sel(st.ser3_data_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[1])
  ); // [RULE3] [RULE14]

  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_REMAPPABLE_PIN_124)
  ) u_mux_ser3_ss (
    .sel(st.ser3_ss_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[2])
  ); // [RULE3] [RULE14]

  // sync and deadtime selectors use the 1111100 code for pin 124
  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_INPUT_ONLY_PIN_124)
  ) u_mux_sync (
    .sel(st.sync_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[3])
  ); // [RULE4] [RULE14]

  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_INPUT_ONLY_PIN_124)
  ) u_mux_dtc1 (
    .sel(st.dtc1_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[4])
  ); // [RULE4] [RULE14]

  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_INPUT_ONLY_PIN_124)
  ) u_mux_dtc2 (
    .sel(st.dtc2_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[5])
  ); // [RULE4] [RULE14]

  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_INPUT_ONLY_PIN_124)
  ) u_mux_dtc3 (
    .sel(st.dtc3_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[6])
  ); // [RULE4] [RULE14]

  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_INPUT_ONLY_PIN_124)
  ) u_mux_dtc4 (
    .sel(st.dtc4_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[7])
  ); // [RULE4] [RULE14]

  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_INPUT_ONLY_PIN_124)
  ) u_mux_dtc5 (
    .sel(st.dtc5_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[8])
  ); // [RULE4] [RULE14]

  rps_input_mux #(
    .NPINS(NPINS),
    .TOP_CODE(`RPS_CODE_INPUT_ONLY_PIN_124)
  ) u_mux_dtc6 (
    .sel(st.dtc6_sel),
    .comparator_one_output(comparator_one_output),
    .pins(pin_in),
    .y(mux_y[9])
  ); // [RULE4] [RULE14]

  always_comb begin
    logic wr;
    logic [31:0] rd;
    logic hit;
    wr = 1'b0;
    rd = 32'h0000_0000;
    hit = 1'b1;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.periph_in = mux_y;
    next_st.pin35_out = fn_pick(st.pin35_fn, periph_func_out);
    next_st.pin20_out = fn_pick(st.pin20_fn, periph_func_out);
    case (paddr)
      `RPS_OFF_SER3_CLK_DATA: begin
        rd = pack2(st.ser3_clk_sel, st.ser3_data_sel); // [RULE7]
      end
      `RPS_OFF_SER3_SS: begin
        rd = pack2(7'h00, st.ser3_ss_sel); // [RULE8]
      end
      `RPS_OFF_MOD_SYNC: begin
        rd = pack2(st.sync_sel, 7'h00); // [RULE9]
      end
      `RPS_OFF_DTC1: begin
        rd = pack2(st.dtc1_sel, 7'h00); // [RULE10]
      end
      `RPS_OFF_DTC23: begin
        rd = pack2(st.dtc3_sel, st.dtc2_sel); // [RULE11]
      end
      `RPS_OFF_DTC45: begin
        rd = pack2(st.dtc5_sel, st.dtc4_sel); // [RULE11]
      end
      `RPS_OFF_DTC6: begin
        rd = pack2(7'h00, st.dtc6_sel); // [RULE10]
      end
      `RPS_OFF_OUT0: begin
        rd[`RPS_HI_LSB +: `RPS_FN_W] = st.pin35_fn;
        rd[`RPS_LO_LSB +: `RPS_FN_W] = st.pin20_fn;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    case (st.bus_state)
      RPS_IDLE: begin
        if (psel && !penable) begin
          next_st.bus_state = RPS_ACCESS;
        end
      end
      RPS_ACCESS: begin
        // answer one cycle into the access phase, registered for timing
        if (psel && penable) begin
          next_st.pready = 1'b1;
          next_st.pslverr = !hit;
          next_st.prdata = pwrite ? 32'h0000_0000 : rd;
          wr = pwrite && hit;
          next_st.bus_state = RPS_DONE;
        end else begin
          next_st.bus_state = RPS_IDLE;
        end
      end
      RPS_DONE: begin
        // a new setup may follow the completion edge at once; missing it
        // would leave the bus waiting for a setup that never comes again
        if (psel && !penable) begin
          next_st.bus_state = RPS_ACCESS;
        end else begin
          next_st.bus_state = RPS_IDLE;
        end
      end
      default: next_st.bus_state = RPS_IDLE;
    endcase
    // only the low byte lanes hold fields; higher bits are not stored
    if (wr) begin
      case (paddr)
        `RPS_OFF_SER3_CLK_DATA: begin
          if (pstrb[1]) begin
            next_st.ser3_clk_sel = hi_field(pwdata); // [RULE7]
          end
          if (pstrb[0]) begin
            next_st.ser3_data_sel = lo_field(pwdata); // [RULE7]
          end
        end
        `RPS_OFF_SER3_SS: begin
          if (pstrb[0]) begin
            next_st.ser3_ss_sel = lo_field(pwdata); // [RULE8]
          end
        end
        `RPS_OFF_MOD_SYNC: begin
          if (pstrb[1]) begin
            next_st.sync_sel = hi_field(pwdata); // [RULE9]
          end
        end
        `RPS_OFF_DTC1: begin
          if (pstrb[1]) begin
            next_st.dtc1_sel = hi_field(pwdata); // [RULE10]
          end
        end
        `RPS_OFF_DTC23: begin
          if (pstrb[1]) begin
            next_st.dtc3_sel = hi_field(pwdata); // [RULE11]
          end
          if (pstrb[0]) begin
            next_st.dtc2_sel = lo_field(pwdata); // [RULE11]
          end
        end
        `RPS_OFF_DTC45: begin
          if (pstrb[1]) begin
            next_st.dtc5_sel = hi_field(pwdata); // [RULE11]
          end
          if (pstrb[0]) begin
            next_st.dtc4_sel = lo_field(pwdata); // [RULE11]
          end
        end
        `RPS_OFF_DTC6: begin
          if (pstrb[0]) begin
            next_st.dtc6_sel = lo_field(pwdata); // [RULE10]
          end
        end
        `RPS_OFF_OUT0: begin
          if (pstrb[1]) begin
            next_st.pin35_fn = pwdata[`RPS_HI_LSB +: `RPS_FN_W]; // [RULE12]
          end
          if (pstrb[0]) begin
            next_st.pin20_fn = pwdata[`RPS_LO_LSB +: `RPS_FN_W]; // [RULE12]
          end
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end
  end // [RULE5]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0; // [RULE6]
      st.bus_state <= RPS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // routed inputs and pin drives lag their fields by one cycle; function field outputs are the fields: each is a flop
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign serial3_clock_input = st.periph_in[0];
  assign serial3_data_input = st.periph_in[1];
  assign serial3_slave_select_input = st.periph_in[2];
  assign modulator_sync_input = st.periph_in[3];
  assign deadtime_comp_input = st.periph_in[9:4];
  assign pin35_drive = st.pin35_out;
  assign pin20_drive = st.pin20_out;
  assign pin35_function_field = st.pin35_fn;
  assign pin20_function_field = st.pin20_fn;
endmodule : rps_pin_select
`default_nettype wire

// ==== tb/rps_pin_select_asserts.sv ====
// port assertions for the pin select unit
`timescale 1ns/10ps
`default_nettype none
module rps_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pin35_drive,
  input wire logic [5:0] pin35_function_field
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic acc;
  // access cycle still waiting for its answer
  assign acc = psel && penable && !pready;
  answer_time_a: assert property (psel && !penable |-> ##2 pready)
    else $error("no answer two cycles after setup");
  answer_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  unmapped_err_a: assert property (acc && paddr > 12'h01C |=> pslverr)
    else $error("unmapped access not flagged");
  spare_zero_a: assert property (pready |-> prdata[31:15] == '0)
    else $error("unimplemented read bits not zero");
  pin35_write_a: assert property (
    acc && pwrite && paddr == 12'h01C && pstrb[1]
    |=> pin35_function_field == pwdata[13:8])
    else $error("pin 35 function field not written");
  pin35_read_a: assert property (
    pready && !pwrite && paddr == 12'h01C
    |-> prdata[13:8] == pin35_function_field)
    else $error("pin 35 function field read back wrong");
  field_hold_a: assert property (
    $changed(pin35_function_field) |-> $past(penable) && $past(pwrite))
    else $error("function field changed without a write");
  fn_none_a: assert property (pin35_function_field == '0 |=> !pin35_drive)
    else $error("pin 35 driven with no function");
endmodule : rps_checker
bind rps_pin_select rps_checker chk_u (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin35_drive(pin35_drive),
  .pin35_function_field(pin35_function_field));
`default_nettype wire

// ==== tb/rps_far_side.sv ====
// pins, comparator and peripheral outputs seen by the pin select unit
`timescale 1ns/10ps
`default_nettype none
module rps_far_side (
  input wire logic flip,
  output logic comparator_one_output,
  output logic [127:0] pin_in,
  output logic [63:0] periph_func_out
);
  // neighbouring pins differ, except where bit 3 changes (7/8, 15/16, 23/24, ...), so a wrong pin index shows up
  always_comb begin
    comparator_one_output = ~flip;
    for (int n = 0; n < 128; n++)
      pin_in[n] = n[0] ^ n[3] ^ flip;
    for (int n = 0; n < 64; n++)
      periph_func_out[n] = n[1] ^ flip;
  end
endmodule : rps_far_side
`default_nettype wire

// ==== tb/rps_pin_select_tb_top.sv ====
// self-checking bench for the pin select unit
`timescale 1ns/10ps
`default_nettype none
module rps_pin_select_tb_top;
  localparam logic [15:0] MASK [9] = '{16'h7F7F, 16'h007F, 16'h7F00,
    16'h7F00, 16'h7F7F, 16'h7F7F, 16'h007F, 16'h3F3F, 16'h0000};
  logic clock = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, flip = 1'h0, pready, pslverr, er;
  logic s3c, s3d, s3s, syn, cmp, p35, p20;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, d;
  logic [3:0] pstrb = '0;
  logic [5:0] dt, f35, f20;
  logic [15:0] bm, m [9];
  logic [127:0] pins;
  logic [63:0] fo;
  int miscompares = 0, n_compared = 0, seed = 52, i;

  rps_far_side far_u (.flip(flip), .comparator_one_output(cmp),
    .pin_in(pins), .periph_func_out(fo));
  rps_pin_select dut_u (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_one_output(cmp), .pin_in(pins), .periph_func_out(fo),
    .serial3_clock_input(s3c), .serial3_data_input(s3d),
    .serial3_slave_select_input(s3s), .modulator_sync_input(syn),
    .deadtime_comp_input(dt), .pin35_drive(p35), .pin20_drive(p20),
    .pin35_function_field(f35), .pin20_function_field(f20));

  initial forever #5 clock = ~clock;

  function automatic logic lvl(int n);
    return n[0] ^ n[3] ^ flip;
  endfunction : lvl
  function automatic logic src(logic [6:0] c, logic s3);
    if (c == 7'h00)
      return 1'h0;
    if (c == 7'h01)
      return ~flip;
    if (c == (s3 ? 7'h7F : 7'h7C))
      return lvl(124);
    return lvl(c);
  endfunction : src
  function automatic logic drv(logic [5:0] f);
    return (|f) & (f[1] ^ flip);
  endfunction : drv
  // endpoint codes come up often, the rest at random
  function automatic logic [6:0] pick;
    case ($unsigned($random(seed)) % 5)
      0: return 7'h00;
      1: return 7'h01;
      2: return 7'h7C;
      3: return 7'h7F;
      default: return 7'($random(seed));
    endcase
  endfunction : pick

  task automatic chk(input logic [39:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] dd, input logic [3:0] s);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= 12'(i * 4);
    pwdata <= dd;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'h1;
    do
      @(posedge clock);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    for (i = 0; i < 9; i++) begin
      m[i] = '0;
      apb(1'h0, '0, '0);
      chk({er, rd}, {i == 8, 32'h0});
    end
    $display("reset value test done");
    for (int t = 0; t < 90; t++) begin
      i = $unsigned($random(seed)) % 9;
      d = $random(seed);
      d[14:8] = pick();
      d[6:0] = pick();
      flip <= 1'($random(seed));
      apb(1'h1, d, 4'($random(seed)));
      bm = {{8{pstrb[1]}}, {8{pstrb[0]}}} & MASK[i];
      m[i] = m[i] & ~bm | d[15:0] & bm;
      chk(er, i == 8);
      apb(1'h0, '0, '0);
      chk({er, rd}, {i == 8, 16'h0, m[i]});
      repeat (2) @(posedge clock);
      chk({s3c, s3d, s3s, syn, dt, p35, p20, f35, f20}, {src(m[0][14:8], 1'h1),
        src(m[0][6:0], 1'h1), src(m[1][6:0], 1'h1), src(m[2][14:8], 1'h0),
        src(m[6][6:0], 1'h0), src(m[5][14:8], 1'h0), src(m[5][6:0], 1'h0),
        src(m[4][14:8], 1'h0), src(m[4][6:0], 1'h0), src(m[3][14:8], 1'h0),
        drv(m[7][13:8]), drv(m[7][5:0]), m[7][13:8], m[7][5:0]});
    end
    $display("random access test done");
    report_and_stop();
  end
endmodule : rps_pin_select_tb_top
`default_nettype wire
